// File: rtl/fault_warning_pin_control.sv
// Fault and warning pin aggregation, mute/standby control, target address straps.
// Assumes analog detectors drive levels asynchronously; clip timing runs on the PWM clock.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "fault_warning_pin_control_cfg.svh"

// Operation
// [RL1] Fault pin goes low on channel, thermal shutdown, supply or clock faults.
// [RL2] Fault pin stays low until host writes clear bit 7 of 0x21.
// [RL3] Fault status bits stay set until clear bit is written.
// [RL4] Fault masks gate only the pin; all unmasked after reset.
// [RL5] Warning pin goes low on clip, overtemp warning, current limit, power-on.
// [RL6] Clip flagged after window of consecutive full-modulation PWM clocks, default 20.
// [RL7] Latching clip status stays set until clear bit is written.
// [RL8] Overtemp warning from global or any channel warning; threshold in 0x01.
// [RL9] Clip, overtemp and current-limit masks gate only the warning pin.
// [RL10] Warning pin latches low until clear bit is written.
// [RL11] Mute input low mutes all channels; high unmutes them.
// [RL12] Standby input low shuts down, ramping outputs down in under 5 ms.
// [RL13] Mute switches at half duty without audio; play switches with audio.
// [RL14] Host holds standby low 15 ms before removing supplies.
// [RL15] Device is only a target on the control bus.
// [RL16] Straps pick write address D4/D6/D8/DA; read address is one higher.
// [RL17] Power-on sets the power-on warning bit and drives warning pin low.
// [RL18] Current limiting is never a fault; only warning pin and 0x25.
// [RL19] Clear bit is a self-clearing strobe clearing all sticky bits and pins.
module fault_warning_pin_control #(
   parameter int unsigned RAMP_CYCLES = `RAMP_TIME_MS * (`MCLK_HZ / 1000)
) (
   input  wire logic                                i_mclk,      // Control clock
   input  wire logic                                i_srst,      // Sync reset, high
   input  wire logic                                i_ce,        // Clock enable
   input  wire logic                                i_pwm_clk,   // PWM clock
   input  wire logic [3:0]                          i_full_mod,  // Full modulation, PWM dom
   input  wire fault_warning_pin_control_pkg::pin_in_s i_pins,   // Async pin levels
   input  wire logic [7:0]                          i_addr,      // Register address
   input  wire logic [7:0]                          i_wdata,     // Write data
   input  wire logic                                i_wr,        // Write strobe
   input  wire logic                                i_rd,        // Read strobe
   output logic      [7:0]                          o_rdata,     // Read data, next cycle
   output logic                                     o_fault_n,   // Fault pin, low active
   output logic                                     o_warn_n,    // Warning pin, low active
   output fault_warning_pin_control_pkg::amp_state_e o_state,    // Output stage state
   output logic                                     o_osc_run,   // Oscillator enable
   output logic      [7:0]                          o_wr_addr,   // Bus write address
   output logic      [7:0]                          o_rd_addr,   // Bus read address
   output logic      [7:0]                          o_misc1      // Thresholds to analog
);

   localparam int unsigned PW = $bits(fault_warning_pin_control_pkg::pin_in_s);

   // Event wins over clear
   function automatic logic [7:0] sticky8(input logic [7:0] cur, input logic [7:0] ev,
                                          input logic clr);
      sticky8 = (clr ? 8'h00 : cur) | ev;
   endfunction

   // Input synchroniser: a change counts once stages two and three agree
   logic [PW-1:0] sync1;
   logic [PW-1:0] sync2;
   logic [PW-1:0] sync3;

   fault_warning_pin_control_pkg::pin_in_s pins;
   wire  [PW-1:0] next_pins = (sync2 & sync3) | (pins & (sync2 ^ sync3));

   // Clip level back from the PWM domain, same three-stage filter
   logic clip1;
   logic clip2;
   logic clip3;
   logic clip_lvl;

   wire  next_clip_lvl = (clip2 & clip3) | (clip_lvl & (clip2 ^ clip3));

   always_ff @(posedge i_mclk) begin
      if (i_ce) begin
         sync1 <= i_pins;
         sync2 <= sync1;
         sync3 <= sync2;
         clip2 <= clip1;
         clip3 <= clip2;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         pins     <= '0;
         clip_lvl <= 1'b0;
      end else if (i_ce) begin
         pins     <= next_pins;
         clip_lvl <= next_clip_lvl;
      end
   end

   // Software registers
   logic [7:0] misc1;
   logic [7:0] state_ctl;
   logic [7:0] pin_ctl;
   logic [7:0] misc3;
   logic [7:0] clip_win;
   logic       win_tgl;

   wire wr_misc1   = i_wr && (i_addr == `REG_MISC1);
   wire wr_state   = i_wr && (i_addr == `REG_STATE_CTL);
   wire wr_pin_ctl = i_wr && (i_addr == `REG_PIN_CTL);
   wire wr_misc3   = i_wr && (i_addr == `REG_MISC3);
   wire wr_win     = i_wr && (i_addr == `REG_CLIP_WINDOW);

   wire clr        = wr_misc3 && i_wdata[`MISC3_CLEAR];                 // [RL19]

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         misc1     <= `MISC1_RST;
         state_ctl <= `STATE_CTL_RST;
         pin_ctl   <= `PIN_CTL_RST;                                     // [RL4] [RL9]
         misc3     <= `MISC3_RST;
         clip_win  <= `CLIP_WINDOW_RST;                                 // [RL6]
         win_tgl   <= 1'b0;
      end else if (i_ce) begin
         if (wr_misc1) misc1 <= i_wdata;                                // [RL8]
         if (wr_state) state_ctl <= i_wdata;
         if (wr_pin_ctl) pin_ctl <= i_wdata;

         // Clear bit is a strobe and never stored
         if (wr_misc3) misc3 <= i_wdata & ~(8'h01 << `MISC3_CLEAR);      // [RL19]

         if (wr_win) begin
            clip_win <= i_wdata;
            win_tgl  <= ~win_tgl;
         end
      end
   end

   // Events from the filtered detector levels
   wire [7:0] ev_ch   = {pins.ch_overcurrent, pins.ch_dc_offset};
   wire [7:0] ev_glb  = {2'h0, pins.overtemp_shutdown, pins.clock_error,
                         pins.supply_ov, pins.supply_uv};
   wire       otw_any = pins.overtemp_warning | (|pins.ch_overtemp_warning);  // [RL8]
   wire       ilim_any = |pins.current_limit_event;
   wire       clip_nl = misc3[`MISC3_CLIP_NL];

   logic [7:0] ch_fault;
   logic [7:0] glb_fault;
   logic [7:0] warnings;
   logic [7:0] curlim;

   wire [7:0] ev_warn = {pins.ch_overtemp_warning, 1'b0, 1'b0, otw_any, clip_lvl};
   wire [7:0] next_warnings_l = sticky8(warnings, ev_warn, clr);       // [RL7]
   // Non-latching clip mode: status follows the live level
   wire [7:0] next_warnings = clip_nl ?
              {next_warnings_l[7:1], clip_lvl} : next_warnings_l;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ch_fault  <= 8'h00;
         glb_fault <= 8'h00;
         warnings  <= 8'h01 << `WARN_POR;                               // [RL17]
         curlim    <= 8'h00;
      end else if (i_ce) begin
         ch_fault  <= sticky8(ch_fault, ev_ch, clr);                    // [RL3]
         glb_fault <= sticky8(glb_fault, ev_glb, clr);                  // [RL3]
         warnings  <= next_warnings;
         curlim    <= sticky8(curlim, {4'h0, pins.current_limit_event}, clr);  // [RL18]
      end
   end

   // Pin events; masks act only here, never on status or protection
   wire fault_ev =
      ((|ev_ch) & ~pin_ctl[`MASK_CH_FAULT]) |                           // [RL1] [RL4]
      (pins.overtemp_shutdown & ~pin_ctl[`MASK_OVERTEMP_SHUTDOWN]) |
      ((|{pins.supply_ov, pins.supply_uv}) & ~pin_ctl[`MASK_VOLTAGE]) |
      (pins.clock_error & ~pin_ctl[`MASK_CLK_ERR]);

   // Current limit feeds only the warning side
   wire warn_ev =
      (clip_lvl & ~pin_ctl[`MASK_CLIP]) |                               // [RL5] [RL9]
      (otw_any & ~pin_ctl[`MASK_OTW]) |
      (ilim_any & ~pin_ctl[`MASK_CURLIM]);                              // [RL18]

   wire next_fault_n = ~((clr ? 1'b0 : ~o_fault_n) | fault_ev);         // [RL2]
   wire next_warn_n  = ~((clr ? 1'b0 : ~o_warn_n) | warn_ev);           // [RL10]

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_fault_n <= 1'b1;
         o_warn_n  <= 1'b0;                                             // [RL17]
      end else if (i_ce) begin
         o_fault_n <= next_fault_n;
         o_warn_n  <= next_warn_n;
      end
   end

   // Output stage control
   wire auto_rec   = misc3[`MISC3_AUTO_REC];
   wire live_fault = (|ev_ch) | (|ev_glb);

   // Without auto-recovery a shutdown holds until the clear strobe
   wire protect    = auto_rec ? live_fault : ((|ch_fault) | (|glb_fault) | live_fault);
   wire go_hiz     = protect | state_ctl[`STATE_SW_HIZ];
   wire mute_req   = ~pins.mute_n | state_ctl[`STATE_SW_MUTE];          // [RL11]
   wire stby_req   = ~pins.standby_n;

   logic [$clog2(RAMP_CYCLES+1)-1:0] ramp_cnt;
   wire ramp_done = (ramp_cnt == '0);
   fault_warning_pin_control_pkg::amp_state_e next_state;

   always_comb begin
      next_state = o_state;
      unique case (o_state)
         fault_warning_pin_control_pkg::ST_STANDBY: begin
            if (!stby_req) next_state = fault_warning_pin_control_pkg::ST_HIZ;
         end

         fault_warning_pin_control_pkg::ST_RAMP: begin
            if (ramp_done) next_state = fault_warning_pin_control_pkg::ST_STANDBY;  // [RL12]
         end

         fault_warning_pin_control_pkg::ST_HIZ: begin
            if (stby_req) next_state = fault_warning_pin_control_pkg::ST_STANDBY;
            else if (!go_hiz) next_state = fault_warning_pin_control_pkg::ST_MUTE;
         end

         fault_warning_pin_control_pkg::ST_MUTE: begin
            if (stby_req) next_state = fault_warning_pin_control_pkg::ST_RAMP;
            else if (go_hiz) next_state = fault_warning_pin_control_pkg::ST_HIZ;
            else if (!mute_req) next_state = fault_warning_pin_control_pkg::ST_PLAY;  // [RL11]
         end

         fault_warning_pin_control_pkg::ST_PLAY: begin
            if (stby_req) next_state = fault_warning_pin_control_pkg::ST_RAMP;  // [RL12]
            else if (go_hiz) next_state = fault_warning_pin_control_pkg::ST_HIZ;
            else if (mute_req) next_state = fault_warning_pin_control_pkg::ST_MUTE;  // [RL13]
         end

         default: next_state = fault_warning_pin_control_pkg::ST_HIZ;
      endcase
   end

   wire entering_ramp = (next_state == fault_warning_pin_control_pkg::ST_RAMP) &&
                        (o_state != fault_warning_pin_control_pkg::ST_RAMP);

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_state   <= fault_warning_pin_control_pkg::ST_STANDBY;
         o_osc_run <= 1'b0;
         ramp_cnt  <= '0;
      end else if (i_ce) begin
         o_state   <= next_state;
         // Oscillator stops only in standby; the register port stays live
         o_osc_run <= (next_state != fault_warning_pin_control_pkg::ST_STANDBY);  // [RL13]
         // Ramp ends a cycle inside its limit
         if (entering_ramp) ramp_cnt <= $bits(ramp_cnt)'(RAMP_CYCLES - 2);        // [RL12]
         else if (!ramp_done) ramp_cnt <= ramp_cnt - 1'b1;
      end
   end

   // Straps are captured once, after the filter has settled
   logic [2:0] strap_wait;

   wire [1:0] strap = {pins.target_addr_strap_hi, pins.target_addr_strap_lo};
   wire [7:0] next_wr_addr = 8'(`TARGET_WR_BASE + {5'h00, strap, 1'b0});  // [RL16]

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         strap_wait <= `STRAP_SETTLE;
         o_wr_addr  <= `TARGET_WR_BASE;
         o_rd_addr  <= 8'(`TARGET_WR_BASE + 8'h01);
      end else if (i_ce && strap_wait != 3'h0) begin
         strap_wait <= strap_wait - 3'h1;
         if (strap_wait == 3'h1) begin
            o_wr_addr <= next_wr_addr;                                  // [RL15] [RL16]
            o_rd_addr <= 8'(next_wr_addr + 8'h01);                      // [RL16]
         end
      end
   end

   // Register read port; unmapped addresses read zero
   wire [7:0] rd_mux =
      (i_addr == `REG_MISC1)       ? misc1 :
      (i_addr == `REG_STATE_CTL)   ? state_ctl :
      (i_addr == `REG_STATE_RPT)   ? {5'h00, o_state} :
      (i_addr == `REG_CH_FAULT)    ? ch_fault :
      (i_addr == `REG_GLB_FAULT)   ? glb_fault :
      (i_addr == `REG_WARNINGS)    ? warnings :
      (i_addr == `REG_PIN_CTL)     ? pin_ctl :
      (i_addr == `REG_MISC3)       ? misc3 :
      (i_addr == `REG_CLIP_WINDOW) ? clip_win :
      (i_addr == `REG_CURLIM)      ? curlim : 8'h00;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_rdata <= 8'h00;
         o_misc1 <= `MISC1_RST;
      end else if (i_ce) begin
         o_rdata <= i_rd ? rd_mux : 8'h00;
         o_misc1 <= misc1;                                              // [RL8]
      end
   end

   // PWM domain: clip window counting
   logic [1:0] prst;
   logic       tg1;
   logic       tg2;
   logic       tg3;

   logic [7:0] p_win;
   logic [7:0] p_cnt [4];
   logic       p_clip;

   wire        p_rst = prst[1];

   always_ff @(posedge i_pwm_clk) begin
      prst <= {prst[0], i_srst};
      tg1  <= win_tgl;
      tg2  <= tg1;
      tg3  <= tg2;
   end

   // Window word is held steady in the control domain until the toggle lands
   logic [3:0] p_hit;

   always_comb begin
      for (int c = 0; c < 4; c++) begin
         p_hit[c] = (p_cnt[c] != 8'h00) && (p_cnt[c] >= p_win);         // [RL6]
      end
   end

   always_ff @(posedge i_pwm_clk) begin
      if (p_rst) begin
         p_win  <= `CLIP_WINDOW_RST;
         p_clip <= 1'b0;
         for (int c = 0; c < 4; c++) p_cnt[c] <= 8'h00;
      end else begin
         if (tg2 != tg3) p_win <= clip_win;
         p_clip <= |p_hit;
         for (int c = 0; c < 4; c++) begin
            if (!i_full_mod[c]) p_cnt[c] <= 8'h00;                      // [RL6]
            else if (p_cnt[c] != 8'hFF) p_cnt[c] <= p_cnt[c] + 8'h01;
         end
      end
   end

   // Back into the control domain
   always_ff @(posedge i_mclk) begin
      if (i_ce) clip1 <= p_clip;
   end

endmodule // fault_warning_pin_control

// File: rtl/fault_warning_pin_control_cfg.svh
// Offsets, field positions, reset values and timing for the fault/warning pin block.
// Assumes 8-bit register data on a plain strobe port and a 50 MHz control clock.
`ifndef FAULT_WARNING_PIN_CONTROL_CFG_SVH
`define FAULT_WARNING_PIN_CONTROL_CFG_SVH

`define REG_MISC1        8'h01
`define REG_STATE_CTL    8'h04
`define REG_STATE_RPT    8'h0F
`define REG_CH_FAULT     8'h10
`define REG_GLB_FAULT    8'h11
`define REG_WARNINGS     8'h13
`define REG_PIN_CTL      8'h14
`define REG_MISC3        8'h21
`define REG_CLIP_WINDOW  8'h23
`define REG_CURLIM       8'h25

`define MISC1_RST        8'h00
`define STATE_CTL_RST    8'h02
`define PIN_CTL_RST      8'h00
`define MISC3_RST        8'h00
`define CLIP_WINDOW_RST  8'h14

`define MISC1_ILIM_LVL   4
`define MISC1_OTW_LO     5
`define MISC1_OTW_HI     6
`define STATE_SW_MUTE    0
`define STATE_SW_HIZ     1
`define MISC3_AUTO_REC   3
`define MISC3_CLIP_NL    6
`define MISC3_CLEAR      7

`define MASK_CH_FAULT    0
`define MASK_OVERTEMP_SHUTDOWN        1
`define MASK_VOLTAGE     2
`define MASK_CLK_ERR     3
`define MASK_CLIP        4
`define MASK_OTW         5
`define MASK_CURLIM      6

`define WARN_CLIP        0
`define WARN_OTW         1
`define WARN_POR         2

`define TARGET_WR_BASE   8'hD4
`define STRAP_SETTLE     3'h5
`define MCLK_HZ          50000000
`define RAMP_TIME_MS     5

`endif

// File: rtl/fault_warning_pin_control_pkg.sv
// Types shared by the fault/warning pin block and its bench.
// Assumes the constants in fault_warning_pin_control_cfg.svh.
package fault_warning_pin_control_pkg;

   // Output stage state, Gray coded along standby -> hiz -> mute -> play
   typedef enum logic [2:0] {
      ST_STANDBY = 3'h0,
      ST_RAMP    = 3'h6,
      ST_HIZ     = 3'h1,
      ST_MUTE    = 3'h3,
      ST_PLAY    = 3'h2
   } amp_state_e;

   // Asynchronous inputs, carried together through the synchroniser
   typedef struct packed {
      logic       mute_n;
      logic       standby_n;
      logic       target_addr_strap_hi;
      logic       target_addr_strap_lo;
      logic [3:0] ch_overcurrent;
      logic [3:0] ch_dc_offset;
      logic       overtemp_shutdown;
      logic [1:0] supply_uv;
      logic [1:0] supply_ov;
      logic       clock_error;
      logic       overtemp_warning;
      logic [3:0] ch_overtemp_warning;
      logic [3:0] current_limit_event;
   } pin_in_s;

endpackage

// File: testbench/fault_warning_pin_control_checker.sv
// Port-level checks of the fault/warning pin block.
// Assumes a bind onto fault_warning_pin_control; all checks run on the control clock.
`timescale 1ns/1ns
module fault_warning_pin_control_checker #(
   parameter int unsigned RAMP_CYCLES = 250000
) (
   input wire logic                                     i_mclk,   // Control clock
   input wire logic                                     i_srst,   // Sync reset
   input wire logic                                     i_ce,     // Clock enable
   input wire logic [7:0]                               i_addr,   // Address
   input wire logic [7:0]                               i_wdata,  // Write data
   input wire logic                                     i_wr,     // Write strobe
   input wire logic                                     i_rd,     // Read strobe
   input wire logic [7:0]                               o_rdata,  // Read data
   input wire logic                                     o_fault_n,// Fault pin
   input wire logic                                     o_warn_n, // Warning pin
   input wire fault_warning_pin_control_pkg::amp_state_e o_state, // Stage state
   input wire logic                                     o_osc_run,// Oscillator
   input wire logic [7:0]                               o_wr_addr,// Write address
   input wire logic [7:0]                               o_rd_addr,// Read address
   input wire logic [7:0]                               o_misc1   // Threshold copy
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   wire         clr_wr = i_ce && i_wr && (i_addr == 8'h21) && i_wdata[7];
   int unsigned ramp_cnt;

   // Ramp length counted here, far beyond any delay range
   always_ff @(posedge i_mclk) begin
      if (i_srst || o_state != fault_warning_pin_control_pkg::ST_RAMP) ramp_cnt <= 0;
      else if (i_ce) ramp_cnt <= ramp_cnt + 1;
   end

   sequence s_fault_held;
      !o_fault_n && !clr_wr;
   endsequence
   sequence s_warn_held;
      !o_warn_n && !clr_wr;
   endsequence
   sequence s_rd_clear_reg;
      i_ce && i_rd && (i_addr == 8'h21);
   endsequence

   property p_fault_sticky;
      s_fault_held |=> !o_fault_n;
   endproperty
   property p_warn_sticky;
      s_warn_held |=> !o_warn_n;
   endproperty
   property p_rd_idle;
      i_ce && !i_rd |=> o_rdata == 8'h00;
   endproperty
   property p_warn_por;
      $fell(i_srst) |-> !o_warn_n;
   endproperty
   property p_addr;
      o_rd_addr == o_wr_addr + 8'h01 && o_wr_addr inside {8'hD4, 8'hD6, 8'hD8, 8'hDA};
   endproperty
   property p_osc;
      o_osc_run == (o_state != fault_warning_pin_control_pkg::ST_STANDBY);
   endproperty
   property p_misc1;
      i_ce && i_wr && (i_addr == 8'h01) |-> ##2 o_misc1 == $past(i_wdata, 2);
   endproperty
   property p_clr_self;
      s_rd_clear_reg |=> o_rdata[7] == 1'b0;
   endproperty
   property p_ramp;
      ramp_cnt < RAMP_CYCLES;
   endproperty

   a_fault_sticky: assert property (p_fault_sticky) else $error("fault pin released");
   a_warn_sticky: assert property (p_warn_sticky) else $error("warn pin released");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   a_warn_por: assert property (p_warn_por) else $error("no power-on warning");
   a_addr: assert property (p_addr) else $error("bad target address pair");
   a_osc: assert property (p_osc) else $error("oscillator run wrong");
   a_misc1: assert property (p_misc1) else $error("threshold copy wrong");
   a_clr_self: assert property (p_clr_self) else $error("clear bit reads one");
   a_ramp: assert property (p_ramp) else $error("ramp down too long");
endmodule // fault_warning_pin_control_checker

bind fault_warning_pin_control fault_warning_pin_control_checker #(
   .RAMP_CYCLES(RAMP_CYCLES)
) u_fault_warning_pin_control_checker (
   .i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fault_n(o_fault_n),
   .o_warn_n(o_warn_n), .o_state(o_state), .o_osc_run(o_osc_run),
   .o_wr_addr(o_wr_addr), .o_rd_addr(o_rd_addr), .o_misc1(o_misc1)
);

// File: testbench/pwm_source_model.sv
// Modulator side model: free-running PWM clock and full-modulation levels.
// Assumes the bench requests clipping channels by level; clock unrelated to control clock.
`timescale 1ns/1ns
module pwm_source_model (
   input  wire logic [3:0] i_clip_req,  // Channels to hold at full modulation
   output logic            o_pwm_clk,   // PWM clock, 80 ns
   output logic [3:0]      o_full_mod   // Full modulation levels
);
   initial begin
      o_pwm_clk = 1'b0;
      o_full_mod = 4'h0;
      #7;
      forever #40 o_pwm_clk = ~o_pwm_clk;
   end
   // Levels move only after a PWM edge, as the modulator's would
   always @(posedge o_pwm_clk) o_full_mod <= i_clip_req;
endmodule // pwm_source_model

// File: testbench/tb_top.sv
// Self-checking bench for the fault/warning pin block.
// Assumes the PWM source model and the bound checker; short ramp for simulation.
`timescale 1ns/1ns
module tb_top;
   localparam int unsigned RAMP = 20;
   logic                                      i_mclk, i_srst, i_ce, i_wr, i_rd;
   logic [7:0]                                i_addr, i_wdata, o_rdata, o_wr_addr, o_rd_addr;
   logic [7:0]                                o_misc1, rv;
   logic                                      o_fault_n, o_warn_n, o_osc_run, pwm_clk;
   logic [3:0]                                clip_req, full_mod;
   fault_warning_pin_control_pkg::pin_in_s    pins;
   fault_warning_pin_control_pkg::amp_state_e o_state;
   int                                        mismatches, tests_run, cycles;
   logic [7:0] ev_addr [9] = '{8'h10, 8'h10, 8'h11, 8'h11, 8'h11, 8'h11, 8'h13, 8'h13, 8'h25};
   logic [7:0] ev_val [9] = '{8'h10, 8'h04, 8'h20, 8'h02, 8'h04, 8'h10, 8'h02, 8'h82, 8'h04};

   fault_warning_pin_control #(.RAMP_CYCLES(RAMP)) u_fault_warning_pin_control (
      .i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_pwm_clk(pwm_clk),
      .i_full_mod(full_mod), .i_pins(pins), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fault_n(o_fault_n),
      .o_warn_n(o_warn_n), .o_state(o_state), .o_osc_run(o_osc_run),
      .o_wr_addr(o_wr_addr), .o_rd_addr(o_rd_addr), .o_misc1(o_misc1));
   pwm_source_model u_pwm_source_model (
      .i_clip_req(clip_req), .o_pwm_clk(pwm_clk), .o_full_mod(full_mod));

   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   task automatic test_done();
      $display("Checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(what, exp, o_rdata);
   endtask
   task automatic pins_chk(input logic f, input logic w);
      chk("fault_pin", {7'h00, f}, {7'h00, o_fault_n});
      chk("warn_pin", {7'h00, w}, {7'h00, o_warn_n});
   endtask
   task automatic st_chk(input fault_warning_pin_control_pkg::amp_state_e s);
      chk("state", {5'h00, s}, {5'h00, o_state});
   endtask
   task automatic set_ev(input int k, input logic v);
      case (k)
         0: pins.ch_overcurrent[0] <= v;
         1: pins.ch_dc_offset[2] <= v;
         2: pins.overtemp_shutdown <= v;
         3: pins.supply_uv[1] <= v;
         4: pins.supply_ov[0] <= v;
         5: pins.clock_error <= v;
         6: pins.overtemp_warning <= v;
         7: pins.ch_overtemp_warning[3] <= v;
         default: pins.current_limit_event[2] <= v;
      endcase
   endtask

   task automatic t_straps_reset();
      for (int s = 0; s < 4; s++) begin
         @(posedge i_mclk);
         {pins.target_addr_strap_hi, pins.target_addr_strap_lo} <= 2'(s);
         i_srst <= 1'b1;
         cyc(8);
         i_srst <= 1'b0;
         cyc(10);
         chk("wr_addr", 8'hD4 + 8'(2 * s), o_wr_addr);
         chk("rd_addr", 8'hD5 + 8'(2 * s), o_rd_addr);
      end
      pins_chk(1'b1, 1'b0);
      rchk("warnings", 8'h13, 8'h04);
      rchk("clip_window", 8'h23, 8'h14);
      rchk("masks", 8'h14, 8'h00);
      rchk("misc3", 8'h21, 8'h00);
      rchk("unmapped", 8'h7F, 8'h00);
      wr(8'h13, 8'hFF);
      rchk("warnings_ro", 8'h13, 8'h04);
      wr(8'h01, 8'h60);
      cyc(1);
      #1 chk("misc1", 8'h60, o_misc1);
   endtask
   task automatic t_state();
      st_chk(fault_warning_pin_control_pkg::ST_HIZ);
      rchk("state_ctl", 8'h04, 8'h02);
      wr(8'h04, 8'h00);
      cyc(10);
      st_chk(fault_warning_pin_control_pkg::ST_PLAY);
      i_ce <= 1'b0;
      pins.mute_n <= 1'b0;
      cyc(10);
      st_chk(fault_warning_pin_control_pkg::ST_PLAY);
      i_ce <= 1'b1;
      cyc(10);
      st_chk(fault_warning_pin_control_pkg::ST_MUTE);
      pins.mute_n <= 1'b1;
      cyc(10);
      st_chk(fault_warning_pin_control_pkg::ST_PLAY);
   endtask
   task automatic t_events();
      wr(8'h21, 8'h80);
      cyc(3);
      pins_chk(1'b1, 1'b1);
      for (int k = 0; k < 9; k++) begin
         set_ev(k, 1'b1);
         cyc(10);
         set_ev(k, 1'b0);
         cyc(10);
         pins_chk(k >= 6, k < 6);
         rchk("status", ev_addr[k], ev_val[k]);
         wr(8'h21, 8'h80);
         cyc(3);
         pins_chk(1'b1, 1'b1);
         rchk("status_clr", ev_addr[k], 8'h00);
      end
   endtask
   task automatic t_masks();
      cyc(10);
      wr(8'h14, 8'h7F);
      pins.ch_overcurrent[1] <= 1'b1;
      pins.overtemp_warning <= 1'b1;
      cyc(10);
      st_chk(fault_warning_pin_control_pkg::ST_HIZ);
      pins.ch_overcurrent[1] <= 1'b0;
      pins.overtemp_warning <= 1'b0;
      cyc(10);
      pins_chk(1'b1, 1'b1);
      rchk("ch_faults", 8'h10, 8'h20);
      rchk("warnings", 8'h13, 8'h02);
      wr(8'h14, 8'h00);
      wr(8'h21, 8'h80);
   endtask
   task automatic t_clip(input int n, input logic [7:0] exp, input logic w);
      clip_req <= 4'h2;
      repeat (n) @(posedge pwm_clk);
      @(posedge i_mclk);
      clip_req <= 4'h0;
      cyc(20);
      rchk("clip_status", 8'h13, exp);
      chk("warn_pin", {7'h00, w}, {7'h00, o_warn_n});
      wr(8'h21, 8'h80);
   endtask
   task automatic t_standby();
      bit saw;
      cyc(10);
      pins.standby_n <= 1'b0;
      for (int i = 0; i < RAMP + 40 && o_state !== fault_warning_pin_control_pkg::ST_STANDBY;
           i++) begin
         @(posedge i_mclk);
         #1 saw |= (o_state === fault_warning_pin_control_pkg::ST_RAMP);
      end
      chk("ramp_seen", 8'h01, {7'h00, saw});
      st_chk(fault_warning_pin_control_pkg::ST_STANDBY);
      chk("osc_run", 8'h00, {7'h00, o_osc_run});
   endtask

   initial begin
      i_srst = 1'b1;
      i_ce = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      clip_req = 4'h0;
      pins = '0;
      pins.standby_n = 1'b1;
      pins.mute_n = 1'b1;
      t_straps_reset();
      t_state();
      t_events();
      t_masks();
      wr(8'h23, 8'h05);
      cyc(10);
      t_clip(3, 8'h00, 1'b1);
      t_clip(10, 8'h01, 1'b0);
      wr(8'h21, 8'h40);
      t_clip(10, 8'h00, 1'b0);
      t_standby();
      test_done();
   end
endmodule // tb_top
